// ### core/sbc_pkg.sv
package sbc_pkg;

  // Divisor width, generator limit and prescaler constants.
  localparam int DIV_W          = 16;
  localparam int DIV_MIN        = 2;
  localparam int PRESCALE_W     = 4;
  localparam logic [3:0] PRESCALE_LAST = 4'hF;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] OFS_DIV_LOW   = 5'h00;
  localparam logic [4:0] OFS_DIV_HIGH  = 5'h04;
  localparam logic [4:0] OFS_CLK_CFG   = 5'h08;
  localparam logic [4:0] OFS_SYNC_IN   = 5'h0C;
  localparam logic [4:0] OFS_CHAR_CTL  = 5'h10;
  localparam logic [4:0] OFS_STATUS    = 5'h14;

  // Clock configuration fields.
  localparam int CFG_PRESCALE_BIT = 0;
  localparam int CFG_FUNC_A_BIT   = 1;
  localparam int CFG_FUNC_B_BIT   = 2;
  localparam int CFG_EXT_RX_BIT   = 3;
  // Synchronous input control fields.
  localparam int SIC_SYNC_EN_BIT  = 0;
  localparam int SIC_CAR_POL_BIT  = 1;
  // Character control fields.
  localparam int CHC_ADDR_EN_BIT  = 0;
  localparam int CHC_ADDR_KIND_BIT = 1;
  // Status fields.
  localparam int STS_RUN_BIT      = 0;
  localparam int STS_GEN_BIT      = 1;
  localparam int STS_AMODE_LSB    = 2;
  localparam int STS_EXPAND_BIT   = 4;
  localparam int STS_CARRIER_BIT  = 5;
  localparam int STS_SYNC_BIT     = 6;

  // Reset values.
  localparam logic [7:0] DIV_BYTE_RST  = 8'h00;
  localparam logic [3:0] CLK_CFG_RST   = 4'h0;
  localparam logic [1:0] SYNC_IN_RST   = 2'h0;
  localparam logic [1:0] CHAR_CTL_RST  = 2'h0;

  // Synchroniser lanes.
  localparam int LN_TX_CLK = 0;
  localparam int LN_RX_CLK = 1;
  localparam int LN_CAR   = 2;
  localparam int LN_DATA  = 3;

  typedef enum logic [1:0] {
    ADDR_NINTH_BIT, ADDR_CHAR_MATCH, ADDR_MATCH_NINTH, ADDR_MATCH_AFTER_BREAK
  } sbc_addr_mode_type;

  typedef enum logic [1:0] {ST_HELD, ST_ARM, ST_RUN} sbc_unit_state_type;

endpackage : sbc_pkg

// ### core/sbc_gen_if.sv
`timescale 1ns/1ps
interface sbc_gen_if #(parameter int DIV_W = 16);
  logic [DIV_W-1:0] divisor;
  logic             load;
  logic             run;
  logic             tick;
  logic             level;

  modport ctrl (output divisor, output load, output run,
                input tick, input level);
  modport gen  (input divisor, input load, input run,
                output tick, output level);
endinterface : sbc_gen_if

// ### core/sbc_baud_gen.sv
`timescale 1ns/1ps
module sbc_baud_gen
  import sbc_pkg::*;
#(
  parameter int GEN_W = 16
) (
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Control side.
  sbc_gen_if.gen   gif
);

  if (GEN_W < 2 || GEN_W > 32) begin : g_bad_width
    $error("sbc_baud_gen: GEN_W must lie between 2 and 32");
  end

  localparam logic [GEN_W-1:0] ONE = {{(GEN_W-1){1'b0}}, 1'b1};

  logic [GEN_W-1:0] cnt;
  logic [GEN_W-1:0] next_cnt;
  logic [GEN_W-1:0] half;
  logic             active;
  logic             phase_p;
  logic             phase_n;

  assign half   = gif.divisor >> 1;
  assign active = gif.run && (gif.divisor >= GEN_W'(DIV_MIN));

  always_comb begin
    if (!active) begin
      next_cnt = '0;
    end else if (gif.load || cnt == '0) begin
      next_cnt = gif.divisor - ONE;
    end else begin
      next_cnt = cnt - ONE;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
    end else if (ce) begin
      cnt <= next_cnt;
    end
  end

  // High for the first half of the period counted on rising edges.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_p <= 1'b0;
    end else if (ce) begin
      phase_p <= active && (next_cnt >= gif.divisor - half);
    end
  end

  // An odd divisor needs the extra half cycle, taken from the falling edge.
  always_ff @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_n <= 1'b0;
    end else if (ce) begin
      phase_n <= phase_p;
    end
  end

  assign gif.level = phase_p | (gif.divisor[0] & phase_n);
  assign gif.tick  = active && !gif.load && cnt == '0;

  // Helper counters read only by the checks below.
  logic [GEN_W-1:0] since;
  logic [GEN_W-1:0] hi_cnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      since  <= '0;
      hi_cnt <= '0;
    end else if (ce) begin
      since  <= (gif.load || gif.tick) ? ONE : since + ONE;
      hi_cnt <= (gif.load || gif.tick) ? '0 : hi_cnt + GEN_W'(phase_p);
    end
  end

  chk_div_stop: assert property (@(posedge clk) disable iff (!nrst)
    (gif.divisor < GEN_W'(DIV_MIN) && !gif.load) |-> (!gif.tick && !phase_p))
    else $error("generator ran with divisor below two");
  chk_gen_period: assert property (@(posedge clk) disable iff (!nrst)
    gif.tick |-> (since == gif.divisor))
    else $error("generator period differs from divisor");
  chk_gen_duty: assert property (@(posedge clk) disable iff (!nrst)
    gif.tick |-> (hi_cnt == half))
    else $error("generator high phase is not half the period");
  chk_load_now: assert property (@(posedge clk) disable iff (!nrst)
    (ce && active && gif.load) |=> (cnt == gif.divisor - ONE))
    else $error("divisor not loaded on start");

endmodule : sbc_baud_gen

// ### core/sbc_top.sv
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module sbc_top
  import sbc_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // Avalon-MM register slave.
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Serial pins.
  input  wire logic        ext_transmit_clock_pin_in,
  output logic             ext_transmit_clock_pin_out,
  output logic             ext_transmit_clock_pin_oe,
  input  wire logic        ext_receive_clock_pin,
  input  wire logic        carrier_gate_input,
  input  wire logic        serial_in_pin,
  // Frame shifter side.
  input  wire logic        tx_data_clock,
  output logic             unit_held_reset,
  output logic             tx_shift_tick,
  output logic             rx_shift_tick,
  output logic             rx_data_sync,
  output logic             serial_expansion,
  output logic             sync_mode,
  output sbc_addr_mode_type address_mode
);

  function automatic logic [4:0] word_addr(input logic [4:0] a);
    return {a[4:2], 2'b00};
  endfunction : word_addr

  function automatic sbc_addr_mode_type addr_mode(input logic en,
                                                  input logic kind,
                                                  input logic sync);
    if (sync) begin
      return ADDR_CHAR_MATCH;
    end else if (!en) begin
      return kind ? ADDR_CHAR_MATCH : ADDR_NINTH_BIT;
    end else begin
      return kind ? ADDR_MATCH_AFTER_BREAK : ADDR_MATCH_NINTH;
    end
  endfunction : addr_mode

  // Registers.
  logic [7:0]         div_low;
  logic [7:0]         div_high;
  logic [3:0]         clock_config_register;
  logic [1:0]         sync_input_control_register;
  logic [1:0]         character_control_register;
  sbc_unit_state_type state;
  sbc_unit_state_type next_state;

  // Bus handshake: one wait state, then the access completes.
  logic acked;
  logic req;
  logic acc_wr;
  logic acc_div;
  logic acc_low;
  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !acked;
  assign acc_wr  = avs_write && acked && avs_byteenable[0];
  assign acc_div = acc_wr && (word_addr(avs_address) == OFS_DIV_LOW ||
                              word_addr(avs_address) == OFS_DIV_HIGH);
  assign acc_low = acc_wr && word_addr(avs_address) == OFS_DIV_LOW;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acked <= 1'b0;
    end else if (ce) begin
      acked <= req && !acked;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_low                     <= DIV_BYTE_RST;
      div_high                    <= DIV_BYTE_RST;
      clock_config_register       <= CLK_CFG_RST;
      sync_input_control_register <= SYNC_IN_RST;
      character_control_register  <= CHAR_CTL_RST;
    end else if (ce && acc_wr) begin
      case (word_addr(avs_address))
        OFS_DIV_LOW:  div_low  <= avs_writedata[7:0];
        OFS_DIV_HIGH: div_high <= avs_writedata[7:0];
        OFS_CLK_CFG:  clock_config_register <= avs_writedata[3:0];
        OFS_SYNC_IN:  sync_input_control_register <= avs_writedata[1:0];
        OFS_CHAR_CTL: character_control_register <= avs_writedata[1:0];
        default: ;
      endcase
    end
  end

  // Unit state: any divisor write holds the unit; the low byte arms it.
  always_comb begin
    next_state = state;
    case (state)
      ST_HELD: next_state = ST_HELD;
      ST_ARM:  next_state = ST_RUN;
      ST_RUN:  next_state = ST_RUN;
      default: next_state = ST_HELD;
    endcase
    if (acc_div) begin
      next_state = acc_low ? ST_ARM : ST_HELD;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_HELD;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign unit_held_reset = state != ST_RUN;

  // Baud rate generator.
  sbc_gen_if #(.DIV_W(DIV_W)) gen_bus ();
  assign gen_bus.divisor = {div_high, div_low};
  assign gen_bus.load    = state == ST_ARM;
  assign gen_bus.run     = state != ST_HELD;

  sbc_baud_gen #(.GEN_W(DIV_W)) u_gen (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .gif  (gen_bus.gen)
  );

  // Two-stage synchronisers for every pin input, plus an edge stage.
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
    end else if (ce) begin
      sync1 <= {serial_in_pin, carrier_gate_input, ext_receive_clock_pin,
                ext_transmit_clock_pin_in};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  logic func_a;
  logic func_b;
  logic prescale;
  logic ext_rx_en;
  logic carrier_active;
  logic tx_ext;
  logic [1:0] src_tick;
  logic [1:0] shift_tick;

  assign sync_mode  = sync_input_control_register[SIC_SYNC_EN_BIT];
  assign func_a     = clock_config_register[CFG_FUNC_A_BIT];
  assign func_b     = clock_config_register[CFG_FUNC_B_BIT];
  assign prescale   = clock_config_register[CFG_PRESCALE_BIT];
  assign ext_rx_en  = clock_config_register[CFG_EXT_RX_BIT];
  assign rx_data_sync = sync2[LN_DATA];
  assign serial_expansion = !sync_mode && func_a && func_b;
  assign address_mode = addr_mode(
    character_control_register[CHC_ADDR_EN_BIT],
    character_control_register[CHC_ADDR_KIND_BIT], sync_mode);

  assign carrier_active = !(sync2[LN_CAR] ^
                            sync_input_control_register[SIC_CAR_POL_BIT]);
  assign tx_ext = func_a && !func_b && !sync_mode;

  // The carrier only matters in synchronous mode, where it gates the external receive clock.
  assign src_tick[0] = tx_ext ? (sync2[LN_TX_CLK] && !sync3[LN_TX_CLK])
                              : gen_bus.tick;
  assign src_tick[1] = ext_rx_en ?
    (sync2[LN_RX_CLK] && !sync3[LN_RX_CLK] &&
     (!sync_mode || carrier_active)) : gen_bus.tick;

  // Per-channel x16 prescaler; channel 0 transmit, channel 1 receive.
  for (genvar ch = 0; ch < 2; ch++) begin : g_presc
    logic [PRESCALE_W-1:0] pcnt;
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        pcnt <= '0;
      end else if (ce) begin
        if (unit_held_reset) begin
          pcnt <= '0;
        end else if (src_tick[ch]) begin
          pcnt <= pcnt + 1'b1;
        end
      end
    end
    assign shift_tick[ch] = !unit_held_reset && src_tick[ch] &&
                            (prescale || pcnt == PRESCALE_LAST);
  end

  assign tx_shift_tick = shift_tick[0];
  assign rx_shift_tick = shift_tick[1];

  // Transmit clock pin drive; the data clock idles high while the unit is held.
  logic pin_oe;
  logic pin_gen_sel;
  logic pin_clk;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_oe      <= 1'b0;
      pin_gen_sel <= 1'b0;
      pin_clk     <= 1'b1;
    end else if (ce) begin
      pin_oe      <= sync_mode ? (func_a || func_b) : func_b;
      pin_gen_sel <= !sync_mode && func_b && !func_a;
      pin_clk     <= unit_held_reset ? 1'b1 : tx_data_clock;
    end
  end

  // The generator level is an OR of flops so its odd half cycle survives.
  assign ext_transmit_clock_pin_oe  = pin_oe;
  assign ext_transmit_clock_pin_out = pin_gen_sel ? gen_bus.level : pin_clk;

  // Register read path.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_read && !acked) begin
      avs_readdata <= 32'h0000_0000;
      case (word_addr(avs_address))
        OFS_DIV_LOW:  avs_readdata[7:0] <= div_low;
        OFS_DIV_HIGH: avs_readdata[7:0] <= div_high;
        OFS_CLK_CFG:  avs_readdata[3:0] <= clock_config_register;
        OFS_SYNC_IN:  avs_readdata[1:0] <= sync_input_control_register;
        OFS_CHAR_CTL: avs_readdata[1:0] <= character_control_register;
        OFS_STATUS: begin
          avs_readdata[STS_RUN_BIT]     <= state == ST_RUN;
          avs_readdata[STS_GEN_BIT]     <= gen_bus.level;
          avs_readdata[STS_AMODE_LSB+:2] <= address_mode;
          avs_readdata[STS_EXPAND_BIT]  <= serial_expansion;
          avs_readdata[STS_CARRIER_BIT] <= carrier_active;
          avs_readdata[STS_SYNC_BIT]    <= sync_mode;
        end
        default: ;
      endcase
    end
  end

  chk_write_resets: assert property (@(posedge clk) disable iff (!nrst)
    (ce && acc_div) |=> (unit_held_reset && !tx_shift_tick && !rx_shift_tick))
    else $error("divisor write did not hold the unit");
  chk_low_enables: assert property (@(posedge clk) disable iff (!nrst)
    (ce && acc_low) ##1 ce |=> !unit_held_reset)
    else $error("low byte write did not restart the unit");
  chk_prescale_div: assert property (@(posedge clk) disable iff (!nrst)
    (tx_shift_tick && !prescale) |-> (g_presc[0].pcnt == PRESCALE_LAST))
    else $error("transmit shift tick not every sixteenth");
  chk_carrier_gate: assert property (@(posedge clk) disable iff (!nrst)
    (sync_mode && ext_rx_en && !carrier_active) |-> !src_tick[1])
    else $error("receive clock passed without carrier");
  chk_sync_addr: assert property (@(posedge clk) disable iff (!nrst)
    sync_mode |-> (address_mode == ADDR_CHAR_MATCH))
    else $error("address mode other than match in sync mode");
  chk_held_quiet: assert property (@(posedge clk) disable iff (!nrst)
    (state == ST_HELD) |-> (!tx_shift_tick && !rx_shift_tick &&
                            !gen_bus.tick))
    else $error("clocks active while unit held");
  chk_pin_disable: assert property (@(posedge clk) disable iff (!nrst)
    (ce && sync_mode && !func_a && !func_b) |=> !ext_transmit_clock_pin_oe)
    else $error("clock output driven with sync bits 00");

  cov_low_write:  cover property (@(posedge clk) disable iff (!nrst)
    (ce && acc_low) ##2 tx_shift_tick);
  cov_div16_tick: cover property (@(posedge clk) disable iff (!nrst)
    tx_shift_tick && !prescale);
  cov_rx_gated:   cover property (@(posedge clk) disable iff (!nrst)
    sync_mode && ext_rx_en && rx_shift_tick);

endmodule : sbc_top

// ### dv/sbc_peer.sv
`timescale 1ns/1ps
module sbc_peer (
  // Core clock reference and frame control.
  input  wire logic       clk,
  input  wire logic       frame,
  input  wire logic [3:0] half,
  input  wire logic       car_pol,
  // Pins toward the device.
  output logic            clk_pin,
  output logic            carrier,
  output logic            data
);
  logic [3:0] cnt;
  logic       run;

  initial begin
    data = 1'b0;
  end

  // The clock stands low between frames; carrier leads its first rising edge by half cycles.
  always @(posedge clk) begin
    if (!frame) begin
      cnt     <= 4'h0;
      run     <= 1'b0;
      clk_pin <= 1'b0;
      carrier <= !car_pol;
    end else if (!run) begin
      carrier <= car_pol;
      run     <= 1'b1;
    end else if (cnt == half - 4'h1) begin
      cnt     <= 4'h0;
      clk_pin <= !clk_pin;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end

  // Data moves on the falling clock edge only, so it never skews the
  // sampling edge; outside a frame it toggles to expose stale sampling.
  always @(posedge clk) begin
    if (!frame || (run && cnt == half - 4'h1 && clk_pin)) begin
      data <= !data;
    end
  end
endmodule : sbc_peer

// ### dv/sbc_top_tb.sv
`timescale 1ns/1ps
module sbc_top_tb
  import sbc_pkg::*;
;
  logic              clk, nrst, ce, rd, wr, tdc, waitreq;
  logic [4:0]        addr;
  logic [31:0]       wdata, rdata, q, p, seed, h;
  logic [3:0]        be, half;
  logic              pin_out, pin_oe, held, txt, rxt, rxd, expn, syncm;
  logic              frame, car_pol, pclk, car, sdat, pin_in;
  logic [1:0]        hist;
  logic [15:0]       n;
  sbc_addr_mode_type amode;
  int                fail_count, cmp_count;

  assign pin_in = pin_oe ? pin_out : pclk;

  sbc_top dut (
    .clk(clk), .nrst(nrst), .ce(ce),
    .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(waitreq),
    .ext_transmit_clock_pin_in(pin_in),
    .ext_transmit_clock_pin_out(pin_out),
    .ext_transmit_clock_pin_oe(pin_oe),
    .ext_receive_clock_pin(pclk), .carrier_gate_input(car),
    .serial_in_pin(sdat), .tx_data_clock(tdc),
    .unit_held_reset(held), .tx_shift_tick(txt),
    .rx_shift_tick(rxt), .rx_data_sync(rxd),
    .serial_expansion(expn), .sync_mode(syncm), .address_mode(amode)
  );

  sbc_peer peer (
    .clk(clk), .frame(frame), .half(half), .car_pol(car_pol),
    .clk_pin(pclk), .carrier(car), .data(sdat)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift

  function automatic logic tk(input logic rx);
    return rx ? rxt : txt;
  endfunction : tk

  function automatic logic [1:0] exp_mode(input logic s, en, k);
    return s ? 2'h1 : {en, k};
  endfunction : exp_mode

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask : check

  // The request stands until the edge that samples waitrequest low; a hung
  // slave is ended by the watchdog, not here.
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] d, output logic [31:0] r);
    @(posedge clk);
    addr  <= a;
    wr    <= w;
    rd    <= !w;
    wdata <= {24'h000000, d};
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    r = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wreg

  task automatic prog(input logic [3:0] cfg, input logic [1:0] sic,
                      input logic [15:0] dv);
    wreg(OFS_DIV_HIGH, dv[15:8]);
    @(posedge clk);
    @(negedge clk);
    check(held, 1'b1);
    check(txt, 1'b0);
    wreg(OFS_CLK_CFG, {4'h0, cfg});
    wreg(OFS_SYNC_IN, {6'h00, sic});
    wreg(OFS_DIV_LOW, dv[7:0]);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(held, 1'b0);
  endtask : prog

  // Spacing in cycles between two ticks; 1000 means none came.
  task automatic period(input logic rx, output logic [31:0] r);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (tk(rx) !== 1'b1 && k < 1000);
    r = 0;
    do begin
      @(negedge clk);
      r++;
    end while (tk(rx) !== 1'b1 && r < 1000);
  endtask : period

  task automatic finish_test();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // The planned sequence needs about 10600 cycles; allow over five times that.
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    finish_test();
  end

  initial begin
    nrst = 1'b0; ce = 1'b1; rd = 1'b0; wr = 1'b0; addr = 5'h00;
    wdata = 32'h0; be = 4'hF; tdc = 1'b0; frame = 1'b0;
    half = 4'h3; car_pol = 1'b1; seed = 32'h0FAE; hist = 2'h0;
    fail_count = 0; cmp_count = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check(held, 1'b1);
    check(pin_oe, 1'b0);
    check(pin_out, 1'b1);
    // Status shows the carrier active: the idle peer holds it low, which
    // is the active level while the polarity bit is clear.
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 5'(i * 4), 8'h00, q);
      check(q, (i == 5) ? 32'h0000_0020 : 32'h0000_0000);
    end
    // A write without the low byte lane must leave the register alone.
    p = xorshift();
    wreg(OFS_CLK_CFG, {4'h0, p[3:0]});
    be <= 4'hE;
    wreg(OFS_CLK_CFG, {4'h0, ~p[3:0]});
    be <= 4'hF;
    bus(1'b0, OFS_CLK_CFG, 8'h00, q);
    check(q, {28'h0, p[3:0]});
    for (int i = 0; i < 5; i++) begin
      p = xorshift();
      n = (i == 0) ? 16'h0002 : (i == 1) ? 16'h0007 :
          (i == 2) ? 16'h0103 : 16'h0002 + {13'h0, p[2:0]};
      prog(4'h5, 2'h0, n);
      period(1'b0, p);
      check(p, {16'h0, n});
      period(1'b1, p);
      check(p, {16'h0, n});
      h = 0;
      repeat (20 * n) begin
        @(clk);
        #1;
        if (pin_out === 1'b1) h++;
      end
      check(h, 32'(10 * n));
    end
    prog(4'h4, 2'h0, 16'h0003);
    period(1'b0, p);
    check(p, 32'd48);
    prog(4'h5, 2'h0, 16'h0000);
    period(1'b0, p);
    check(p, 32'd1000);
    prog(4'h5, 2'h0, 16'h0001);
    period(1'b0, p);
    check(p, 32'd1000);
    prog(4'h3, 2'h0, 16'h0005);
    frame <= 1'b1;
    period(1'b0, p);
    check(p, 32'd6);
    prog(4'h9, 2'h0, 16'h0005);
    period(1'b1, p);
    check(p, 32'd6);
    frame <= 1'b0;
    prog(4'h9, 2'h1, 16'h0005);
    frame <= 1'b1;
    period(1'b1, p);
    check(p, 32'd1000);
    frame <= 1'b0;
    prog(4'h9, 2'h3, 16'h0005);
    frame <= 1'b1;
    period(1'b1, p);
    check(p, 32'd6);
    for (int j = 0; j < 24; j++) begin
      @(negedge clk);
      if (j >= 2) check(rxd, hist[1]);
      hist = {hist[0], sdat};
    end
    for (int i = 0; i < 32; i++) begin
      p = xorshift();
      @(posedge clk);
      tdc <= p[0];
      wreg(OFS_CLK_CFG, {4'h0, 1'b0, i[1], i[0], 1'b1});
      wreg(OFS_SYNC_IN, {7'h00, i[2]});
      wreg(OFS_CHAR_CTL, {6'h00, i[4], i[3]});
      @(posedge clk);
      @(negedge clk);
      check(pin_oe, i[2] ? (i[0] | i[1]) : i[1]);
      check(expn, !i[2] & i[0] & i[1]);
      check(syncm, i[2]);
      check(amode, exp_mode(i[2], i[3], i[4]));
      if ((i[2] && (i[0] | i[1])) || (i[0] && i[1])) begin
        check(pin_out, tdc);
      end
    end
    finish_test();
  end
endmodule : sbc_top_tb
